// >>> common/seep_pkg.sv
// Shared constants and types of the serial EEPROM slave engine
package seep_pkg;

  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] SEEP_CTRL_OFS = 8'h00;
  localparam logic [7:0] SEEP_STAT_OFS = 8'h04;

  // Control register fields and reset value
  localparam int SEEP_CTRL_EN_BIT = 0;
  localparam logic [31:0] SEEP_CTRL_RST = 32'h0000_0001;

  // Status register field positions
  localparam int SEEP_STAT_BUSY_BIT = 0;
  localparam int SEEP_STAT_ACT_BIT = 1;
  localparam int SEEP_STAT_WP_BIT = 2;
  localparam int SEEP_STAT_PTR_LSB = 8;

  // Array and page geometry
  localparam int SEEP_DEPTH = 256;
  localparam int SEEP_PAGE = 16;
  localparam int SEEP_BYTE_BITS = 8;

  // Four-bit device-type code; value is arbitrary
  localparam logic [3:0] SEEP_DEV_TYPE = 4'h5;

  // Self-timed write cycle, 1.5 ms, at a 50 MHz clock
  localparam int SEEP_TWR_US = 1500;
  localparam int SEEP_CLK_MHZ = 50;
  localparam int SEEP_TWR_CYC = SEEP_TWR_US * SEEP_CLK_MHZ;
  localparam int SEEP_TMR_W = 17;

  // Reset values
  localparam logic [7:0] SEEP_PTR_RST = 8'h00;
  localparam logic [3:0] SEEP_CNT_RST = 4'h0;

  // Chip-select pin levels
  typedef struct packed {
    logic chip_select_bit_high;
    logic chip_select_bit_mid;
    logic chip_select_bit_low;
  } seep_cs_s;

  // Protocol engine states
  typedef enum logic [2:0] {
    SEEP_IDLE,
    SEEP_CTRL,
    SEEP_ADDR,
    SEEP_WDATA,
    SEEP_TX
  } seep_state_e;

endpackage : seep_pkg

// >>> verilog/seep_core.sv
// Two-wire slave protocol engine of a 256-byte serial EEPROM with AHB-Lite status port
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module seep_core
  import seep_pkg::*;
#(
  parameter int WR_CYCLES = SEEP_TWR_CYC
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write strobe
  input wire logic [2:0] hsize, // AHB transfer size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic scl_i, // Serial clock pin
  input wire logic sda_i, // Serial data pin level
  output logic sda_o, // Serial data drive value, always low
  output logic sda_oe, // Serial data pull-down enable
  input wire seep_cs_s cs_pins, // Chip-select pin levels
  input wire logic wp_i // Write-protect pin
);

  // Array, page buffer and protocol state live in one record
  typedef struct packed {
    logic [SEEP_DEPTH-1:0][SEEP_BYTE_BITS-1:0] mem;
    logic [SEEP_PAGE-1:0][SEEP_BYTE_BITS-1:0] pbuf;
    logic [SEEP_PAGE-1:0] pvld;
    logic [7:0] ptr;
    logic [7:0] shreg;
    logic [7:0] txsr;
    logic [3:0] cnt;
    seep_state_e st;
    logic mack;
    logic busy;
    logic [SEEP_TMR_W-1:0] tmr;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [2:0] cs_m;
    logic [2:0] cs_s;
    logic wp_m;
    logic wp_s;
    logic sda_oe;
    logic sda_o;
    logic enable;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [7:0] wr_addr;
  } seep_core_s;

  // Timer counts down to zero, so the load is one less than the cycle count
  localparam logic [SEEP_TMR_W-1:0] TMR_LOAD = SEEP_TMR_W'(WR_CYCLES - 1);

  // Status word: busy, protocol active, protect pin, address pointer
  function automatic logic [31:0] stat_word(input seep_core_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[SEEP_STAT_BUSY_BIT] = s.busy;
    w[SEEP_STAT_ACT_BIT] = (s.st != SEEP_IDLE);
    w[SEEP_STAT_WP_BIT] = s.wp_s;
    w[SEEP_STAT_PTR_LSB +: 8] = s.ptr;
    return w;
  endfunction : stat_word

  seep_core_s q;
  seep_core_s d;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic ahb_go;
  logic [3:0] pidx;
  logic [7:0] bval;
  logic ctl_match;
  logic wr_end;
  logic prot_blk;
  logic commit;
  logic unmapped;
  logic bus_wr;
  logic bus_rd;
  logic [SEEP_PAGE-1:0] page_wr;

  always_comb begin
    scl_rise = q.scl_s & ~q.scl_p;
    scl_fall = ~q.scl_s & q.scl_p;
    // Both clock stages must be high, so a data change near a clock edge is not a condition
    start_det = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop_det = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    // Zero wait states: every transfer is taken in the cycle it is offered
    ahb_go = hsel & htrans[1] & hready;
    unmapped = haddr[31:8] != 24'h00_0000;
    bus_wr = ahb_go & hwrite & ~unmapped;
    bus_rd = ahb_go & ~hwrite;
    // Busy or disabled devices stay silent and wait for the next Start
    ctl_match = (q.shreg[7:4] == SEEP_DEV_TYPE) && (q.shreg[3:1] == q.cs_s) && !q.busy && q.enable;
    // An address-only write leaves nothing buffered, so no cycle starts
    wr_end = stop_det && (q.st == SEEP_WDATA) && (q.pvld != '0);
    // Page lies wholly in one half, so the top pointer bit decides protection
    prot_blk = q.wp_s & q.ptr[7];
    // A blocked page still runs the full timed cycle
    commit = wr_end & ~prot_blk;
  end

  // One commit strobe per page buffer entry
  for (genvar g = 0; g < SEEP_PAGE; g++) begin : g_commit
    assign page_wr[g] = commit & q.pvld[g];
  end

  always_comb begin
    d = q;
    pidx = 4'h0;
    bval = 8'h00;

    // Pin synchronisers; the third stage of the lines feeds edge detection
    d.scl_m = scl_i;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = sda_i;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.cs_m = cs_pins;
    d.cs_s = q.cs_m;
    d.wp_m = wp_i;
    d.wp_s = q.wp_m;

    // Write cycle timer
    if (q.busy) begin
      if (q.tmr == '0) begin
        d.busy = 1'b0;
      end else begin
        d.tmr = q.tmr - 1'b1;
      end
    end

    if (start_det) begin
      // A repeated Start abandons a pending page load without writing
      d.st = SEEP_CTRL;
      d.cnt = SEEP_CNT_RST;
      d.sda_oe = 1'b0;
      d.pvld = '0;
    end else if (stop_det) begin
      d.st = SEEP_IDLE;
      d.cnt = SEEP_CNT_RST;
      d.sda_oe = 1'b0;
      if (wr_end) begin
        d.busy = 1'b1;
        d.tmr = TMR_LOAD;
      end
      for (int i = 0; i < SEEP_PAGE; i++) begin
        if (page_wr[i]) begin
          d.mem[{q.ptr[7:4], 4'(i)}] = q.pbuf[i];
        end
      end
      d.pvld = '0;
    end else if (scl_rise) begin
      // Counter: 0-7 data bits, 8 after the eighth rise, 9 through the acknowledge pulse
      if (q.cnt < 4'd8) begin
        d.shreg = {q.shreg[6:0], q.sda_s};
      end else if (q.st == SEEP_TX) begin
        d.mack = ~q.sda_s;
      end
      if (q.cnt != 4'd9) begin
        d.cnt = q.cnt + 1'b1;
      end
    end else if (scl_fall) begin
      case (q.st)
        SEEP_CTRL: begin
          if (q.cnt == 4'd8) begin
            if (ctl_match) begin
              d.sda_oe = 1'b1;
            end else begin
              d.st = SEEP_IDLE;
            end
          end else if (q.cnt == 4'd9) begin
            d.cnt = SEEP_CNT_RST;
            d.sda_oe = 1'b0;
            if (q.shreg[0]) begin
              d.st = SEEP_TX;
              bval = q.mem[q.ptr];
              d.txsr = bval;
              d.sda_oe = ~bval[7];
              d.ptr = q.ptr + 1'b1;
            end else begin
              d.st = SEEP_ADDR;
            end
          end
        end
        SEEP_ADDR: begin
          if (q.cnt == 4'd8) begin
            d.sda_oe = 1'b1;
            d.ptr = q.shreg;
            d.pvld = '0;
          end else if (q.cnt == 4'd9) begin
            d.cnt = SEEP_CNT_RST;
            d.sda_oe = 1'b0;
            d.st = SEEP_WDATA;
          end
        end
        SEEP_WDATA: begin
          if (q.cnt == 4'd8) begin
            d.sda_oe = 1'b1;
            // The index wraps inside the page, so a long load overwrites the earliest bytes
            pidx = q.ptr[3:0];
            d.pbuf[pidx] = q.shreg;
            d.pvld[pidx] = 1'b1;
            d.ptr = {q.ptr[7:4], q.ptr[3:0] + 4'h1};
          end else if (q.cnt == 4'd9) begin
            d.cnt = SEEP_CNT_RST;
            d.sda_oe = 1'b0;
          end
        end
        SEEP_TX: begin
          if (q.cnt == 4'd8) begin
            d.sda_oe = 1'b0;
          end else if (q.cnt == 4'd9) begin
            d.cnt = SEEP_CNT_RST;
            if (q.mack) begin
              bval = q.mem[q.ptr];
              d.txsr = bval;
              d.sda_oe = ~bval[7];
              d.ptr = q.ptr + 1'b1;
            end else begin
              d.st = SEEP_IDLE;
              d.sda_oe = 1'b0;
            end
          end else if (q.cnt != 4'd0) begin
            // Drive only after the falling edge so bits never move under a high clock
            // Output lags the pin fall by up to three clocks; the master must hold the clock low longer
            d.txsr = {q.txsr[6:0], 1'b0};
            d.sda_oe = ~q.txsr[6];
          end
        end
        SEEP_IDLE: begin
          // Unaddressed: ignore traffic until the next Start
          d.sda_oe = 1'b0;
        end
        default: begin
          d.st = SEEP_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // AHB-Lite slave, zero wait states, always OKAY
    d.hreadyout = 1'b1;
    d.hresp = 1'b0;
    d.sda_o = 1'b0;
    d.wr_pend = 1'b0;
    if (q.wr_pend && q.wr_addr == SEEP_CTRL_OFS) begin
      d.enable = hwdata[SEEP_CTRL_EN_BIT];
    end
    // Writes take effect one cycle later, when the data phase shows hwdata
    if (bus_wr) begin
      d.wr_pend = 1'b1;
      d.wr_addr = haddr[7:0];
    end
    if (bus_rd) begin
      // Unmapped locations read as zero with an OKAY response
      d.hrdata = 32'h0000_0000;
      if (!unmapped && haddr[7:0] == SEEP_CTRL_OFS) begin
        d.hrdata[SEEP_CTRL_EN_BIT] = q.enable;
      end else if (!unmapped && haddr[7:0] == SEEP_STAT_OFS) begin
        d.hrdata = stat_word(q);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.ptr <= SEEP_PTR_RST;
      q.cnt <= SEEP_CNT_RST;
      q.st <= SEEP_IDLE;
      // Lines reset idle high so leaving reset cannot fake a Start or Stop
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.enable <= SEEP_CTRL_RST[SEEP_CTRL_EN_BIT];
      q.hreadyout <= 1'b1;
      // Outputs and write state restart quiet
      q.busy <= 1'b0;
      q.tmr <= '0;
      q.pvld <= '0;
      q.sda_oe <= 1'b0;
      q.sda_o <= 1'b0;
      q.hrdata <= 32'h0000_0000;
      q.hresp <= 1'b0;
      q.wr_pend <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hreadyout;
  assign hresp = q.hresp;
  assign sda_o = q.sda_o;
  assign sda_oe = q.sda_oe;

endmodule : seep_core

// >>> verification/seep_chk.sv
// Assertion checker bound to the serial EEPROM engine
`timescale 1ns/1ps
module seep_chk (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, low active
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic scl_i, // Serial clock
  input wire logic sda_o, // Drive value
  input wire logic sda_oe // Pull-down enable
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  no_wait_a: assert property (hreadyout)
    else $error("slave stalled");
  resp_okay_a: assert property (!hresp)
    else $error("error response");
  drive_low_a: assert property (!sda_o)
    else $error("drive value high");
  unmapped_zero_a: assert property (hsel && htrans[1] && hready && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  ctrl_upper_a: assert property (hsel && htrans[1] && hready && !hwrite && haddr == 32'h0 |=> hrdata[31:1] == 31'h0)
    else $error("control read upper bits set");
  oe_steady_a: assert property (scl_i |-> $stable(sda_oe))
    else $error("data changed while clock high");
  ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("pull-down too short");
  idle_quiet_a: assert property (scl_i [*8] |-> !sda_oe)
    else $error("data driven on idle bus");
endmodule : seep_chk
bind seep_core seep_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .scl_i, .sda_o, .sda_oe);

// >>> verification/seep_mst.sv
// Two-wire bus master model that drives the serial clock
`timescale 1ns/1ps
module seep_mst (
  output logic scl, // Serial clock, stands high between frames
  output logic pull, // High while the master pulls data low
  input wire logic sda // Resolved data line with pull-up
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // Data moves 20 ns after the fall so it never races the clock edge
  task automatic bitx(input logic b, output logic r);
    #20 pull = !b;
    #80 scl = 1'b1;
    #30 r = sda;
    #30 scl = 1'b0;
  endtask : bitx
  // Odd offset keeps the link out of phase with the system clock
  task automatic start;
    #27 pull = 1'b0;
    #80 scl = 1'b1;
    #100 pull = 1'b1;
    #100 scl = 1'b0;
  endtask : start
  task automatic stop;
    #20 pull = 1'b1;
    #80 scl = 1'b1;
    #100 pull = 1'b0;
    #200;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ai, ao);
  endtask : xfer
endmodule : seep_mst

// >>> verification/tb.sv
// Self-checking bench of the serial EEPROM engine
`timescale 1ns/1ps
module tb;
  import seep_pkg::*;
  localparam seep_cs_s CS = 3'b101;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, wp = 1'b0, ak;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hready, hresp, sda_oe, scl, pull, sda;
  logic [7:0] q;
  seep_cs_s csp = CS;
  int n_errors = 0, checks = 0;
  always #10 hclk = !hclk;
  assign sda = !(sda_oe | pull);
  seep_core #(.WR_CYCLES(200)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp, .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe, .cs_pins(csp), .wp_i(wp));
  seep_mst mst (.scl, .pull, .sda);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 9);
    if (hready !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
  endtask : rdy
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask : bus
  task automatic ctl(input logic [3:0] ty, input logic rw, ex);
    mst.start();
    mst.xfer({ty, CS, rw}, 1'b1, q, ak);
    chk(ak, ex);
  endtask : ctl
  task automatic wb(input logic [7:0] d);
    mst.xfer(d, 1'b1, q, ak);
    chk(ak, 1'b0);
  endtask : wb
  task automatic rb(input logic last, input logic [7:0] e);
    mst.xfer(8'hFF, last, q, ak);
    chk(q, e);
  endtask : rb
  task automatic at(input logic [7:0] adr);
    ctl(SEEP_DEV_TYPE, 1'b0, 1'b0);
    wb(adr);
    ctl(SEEP_DEV_TYPE, 1'b1, 1'b0);
  endtask : at
  task automatic poll(input logic busy);
    int k;
    k = 0;
    do begin
      mst.start();
      mst.xfer({SEEP_DEV_TYPE, CS, 1'b0}, 1'b1, q, ak);
      k++;
    end while (ak !== 1'b0 && k < 20);
    mst.stop();
    chk({k > 1, ak}, {busy, 1'b0});
    if (ak !== 1'b0) print_verdict();
  endtask : poll
  task automatic wr(input logic [7:0] adr, d);
    ctl(SEEP_DEV_TYPE, 1'b0, 1'b0);
    wb(adr);
    wb(d);
    mst.stop();
    poll(1'b1);
  endtask : wr
  task automatic t_regs;
    logic [31:0] r;
    bus(1'b0, SEEP_CTRL_OFS, 0, r);
    chk(r, SEEP_CTRL_RST);
    bus(1'b0, 32'h100, 0, r);
    chk(r, 32'h0);
    csp <= 3'b100;
    ctl(SEEP_DEV_TYPE, 1'b0, 1'b1);
    mst.stop();
    bus(1'b1, SEEP_CTRL_OFS, 32'h0, r);
    csp <= CS;
    ctl(SEEP_DEV_TYPE, 1'b0, 1'b1);
    mst.stop();
    bus(1'b1, SEEP_CTRL_OFS, 32'h1, r);
    ctl(SEEP_DEV_TYPE ^ 4'h3, 1'b0, 1'b1);
    mst.stop();
    $display("register and refusal test done");
  endtask : t_regs
  task automatic t_page;
    logic [31:0] r;
    ctl(SEEP_DEV_TYPE, 1'b0, 1'b0);
    wb(8'h0E);
    for (int i = 0; i < 18; i++) wb(8'(8'h30 + i));
    mst.stop();
    bus(1'b0, SEEP_STAT_OFS, 0, r);
    chk(r[SEEP_STAT_BUSY_BIT], 1'b1);
    poll(1'b1);
    at(8'h00);
    for (int k = 0; k < 16; k++) rb(1'b0, 8'(8'h32 + k));
    rb(1'b1, 8'h00);
    mst.stop();
    $display("page write test done");
  endtask : t_page
  task automatic t_prot;
    logic [31:0] r;
    @(posedge hclk);
    wp <= 1'b1;
    wr(8'h80, 8'hA5);
    bus(1'b0, SEEP_STAT_OFS, 0, r);
    chk(r, 32'h0000_8104);
    wr(8'h10, 8'h5A);
    @(posedge hclk);
    wp <= 1'b0;
    wr(8'h81, 8'h66);
    at(8'h80);
    rb(1'b0, 8'h00);
    rb(1'b1, 8'h66);
    mst.stop();
    at(8'h10);
    rb(1'b1, 8'h5A);
    mst.stop();
    $display("write protect test done");
  endtask : t_prot
  task automatic t_cur;
    logic [31:0] r;
    at(8'hFF);
    rb(1'b0, 8'h00);
    rb(1'b1, 8'h32);
    mst.stop();
    ctl(SEEP_DEV_TYPE, 1'b1, 1'b0);
    rb(1'b1, 8'h33);
    mst.stop();
    ctl(SEEP_DEV_TYPE, 1'b0, 1'b0);
    wb(8'h05);
    mst.stop();
    poll(1'b0);
    ctl(SEEP_DEV_TYPE, 1'b1, 1'b0);
    rb(1'b1, 8'h37);
    mst.stop();
    bus(1'b0, SEEP_STAT_OFS, 0, r);
    chk(r, 32'h0000_0600);
    $display("current read test done");
  endtask : t_cur
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
    t_regs();
    t_page();
    t_prot();
    t_cur();
    print_verdict();
  end
endmodule : tb
